// File: inc/fai_regs.vh
`ifndef FAI_REGS_VH
`define FAI_REGS_VH
// register offsets on the host port
`define FAI_ALARM_FLAG_ADDR   8'h0e
`define FAI_EVENT_MASK_ADDR   8'h0f
`define FAI_FAULT_STAT_ADDR   8'h10
`define FAI_FAULT_FLAG_ADDR   8'h11
`define FAI_FAULT_MASK_ADDR   8'h12
`define FAI_MASK_RESET        8'h00
`define FAI_FLAG_RESET        8'h00
// fault bit positions
`define FAI_BATT_OV_BIT       7
`define FAI_BATT_OC_BIT       6
`define FAI_INPUT_OV_BIT      5
`define FAI_INPUT_OC_BIT      4
`define FAI_NEAR_LIMIT_BIT    3
`define FAI_BATT_TEMP_BIT     2
`define FAI_INPUT_TEMP_BIT    1
`define FAI_DIE_TEMP_BIT      0
// near-limit window is 5% of the threshold: value <= thr * 105 / 100
`define FAI_NEAR_PCT          8'h05
`define FAI_THERM_WIDTH       10
`endif

// File: logic/fai_sync2.v
`timescale 1ns/1ns
`default_nettype none
module fai_sync2 #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // fai_sync2
`default_nettype wire

// File: logic/fai_fault_alarm_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "fai_regs.vh"
module fai_fault_alarm_regs (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        regReset,
  input  wire        watchdogExpired,
  input  wire [7:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  input  wire [7:0]  alarmEvents,
  input  wire        battOvervolt,
  input  wire        battOvercurr,
  input  wire        inputOvervolt,
  input  wire        inputOvercurr,
  input  wire [9:0]  battery_thermistor,
  input  wire [9:0]  input_thermistor,
  input  wire [9:0]  battery_temp_fault_level,
  input  wire [9:0]  input_temp_fault_level,
  input  wire [9:0]  dieTemp,
  input  wire [9:0]  die_temp_alarm_level,
  output wire        irq_n
);
  reg  [7:0] event_interrupt_mask;
  reg  [7:0] fault_mask;
  reg  [7:0] alarm_latched_flags;
  reg  [7:0] fault_latched_flags;
  reg  [7:0] fault_live_status;
  wire [7:0] syncAlarm;
  wire [3:0] syncFault;
  wire       thermistor_near_limit_live;
  wire       rdAlarm;
  wire       rdFault;
  wire       wrEventMask;
  wire       wrFaultMask;
  wire       battTempFault;
  wire       inputTempFault;
  wire       dieTempAlarm;
  wire       alarmPending;
  wire       faultPending;
  reg  [7:0] next_alarmFlags;
  reg  [7:0] next_faultFlags;
  reg        irqLine_n;

  // thermistor voltage falls as temperature rises; near means at most 5% above, or below
  function nearLimit;
    input [9:0] reading;
    input [9:0] level;
    reg   [17:0] lhs;
    reg   [17:0] rhs;
    begin
      lhs = {8'h00, reading} * 18'd100;
      rhs = {8'h00, level} * (18'd100 + {10'h000, `FAI_NEAR_PCT});
      nearLimit = (lhs <= rhs);
    end
  endfunction

  // one strobe qualified by one register address
  function strobeAt;
    input       strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      strobeAt = strobe && (addr == target);
    end
  endfunction

  // pin-level events come from the analog side, so synchronise them
  fai_sync2 #(.WIDTH(8)) alarmSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (alarmEvents),
    .syncOut (syncAlarm)
  );
  fai_sync2 #(.WIDTH(4)) faultSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({battOvervolt, battOvercurr, inputOvervolt, inputOvercurr}),
    .syncOut (syncFault)
  );

  assign thermistor_near_limit_live =
    nearLimit(battery_thermistor, battery_temp_fault_level) ||
    nearLimit(input_thermistor, input_temp_fault_level);

  // lower thermistor voltage means hotter, so a fault is a fall below level
  assign battTempFault =
    battery_thermistor < battery_temp_fault_level;
  assign inputTempFault =
    input_thermistor < input_temp_fault_level;
  assign dieTempAlarm = dieTemp > die_temp_alarm_level;

  // converter readings are treated as already in this clock domain
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_live_status <= `FAI_FLAG_RESET;
    else if (regReset)
      fault_live_status <= `FAI_FLAG_RESET;
    else
    begin
      fault_live_status[`FAI_BATT_OV_BIT]    <= syncFault[3];
      fault_live_status[`FAI_BATT_OC_BIT]    <= syncFault[2];
      fault_live_status[`FAI_INPUT_OV_BIT]   <= syncFault[1];
      fault_live_status[`FAI_INPUT_OC_BIT]   <= syncFault[0];
      fault_live_status[`FAI_NEAR_LIMIT_BIT] <= thermistor_near_limit_live;
      fault_live_status[`FAI_BATT_TEMP_BIT]  <= battTempFault;
      fault_live_status[`FAI_INPUT_TEMP_BIT] <= inputTempFault;
      fault_live_status[`FAI_DIE_TEMP_BIT]   <= dieTempAlarm;
    end
  end

  assign rdAlarm     = strobeAt(regRead, regAddr, `FAI_ALARM_FLAG_ADDR);
  assign rdFault     = strobeAt(regRead, regAddr, `FAI_FAULT_FLAG_ADDR);
  // writes to flag and status offsets fall through and are ignored
  assign wrEventMask = strobeAt(regWrite, regAddr, `FAI_EVENT_MASK_ADDR);
  assign wrFaultMask = strobeAt(regWrite, regAddr, `FAI_FAULT_MASK_ADDR);

  // masks: watchdog expiry is deliberately not a reset source here
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_interrupt_mask <= `FAI_MASK_RESET;
      fault_mask           <= `FAI_MASK_RESET;
    end
    else if (regReset)
    begin
      event_interrupt_mask <= `FAI_MASK_RESET;
      fault_mask           <= `FAI_MASK_RESET;
    end
    else
    begin
      if (wrEventMask)
        event_interrupt_mask <= regWdata;
      if (wrFaultMask)
        fault_mask <= regWdata;
    end
  end

  // set beats clear so a same-cycle event survives the read
  always @*
  begin
    next_alarmFlags = rdAlarm ? 8'h00 : alarm_latched_flags;
    next_alarmFlags = next_alarmFlags | syncAlarm;
    next_faultFlags = rdFault ? 8'h00 : fault_latched_flags;
    next_faultFlags = next_faultFlags | fault_live_status;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_latched_flags <= `FAI_FLAG_RESET;
      fault_latched_flags <= `FAI_FLAG_RESET;
    end
    else if (regReset)
    begin
      alarm_latched_flags <= `FAI_FLAG_RESET;
      fault_latched_flags <= `FAI_FLAG_RESET;
    end
    else
    begin
      alarm_latched_flags <= next_alarmFlags;
      fault_latched_flags <= next_faultFlags;
    end
  end

  // read data registered: answer one cycle after the read strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `FAI_ALARM_FLAG_ADDR: regRdata <= alarm_latched_flags;
        `FAI_EVENT_MASK_ADDR: regRdata <= event_interrupt_mask;
        `FAI_FAULT_STAT_ADDR: regRdata <= fault_live_status;
        `FAI_FAULT_FLAG_ADDR: regRdata <= fault_latched_flags;
        `FAI_FAULT_MASK_ADDR: regRdata <= fault_mask;
        default:              regRdata <= 8'h00;
      endcase
    end
  end

  assign alarmPending =
    |(alarm_latched_flags & ~event_interrupt_mask);
  assign faultPending = |(fault_latched_flags & ~fault_mask);

  // registered so the pin cannot glitch while flags and masks update;
  // the cost is one cycle of extra latency from flag to pin
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqLine_n <= 1'b1;
    else
      irqLine_n <= ~(alarmPending | faultPending);
  end

  assign irq_n = irqLine_n;
endmodule // fai_fault_alarm_regs
`default_nettype wire

// File: bench/fai_fault_alarm_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fai_fault_alarm_regs_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       regReset,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       battOvervolt,
  input wire logic       irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic rdM = regRead && regAddr == 8'h0f;
  wire logic rdS = regRead && regAddr == 8'h10;
  wire logic rdF = regRead && regAddr == 8'h11;
  wire logic ov  = battOvervolt && !regReset;
  wire logic nov = !battOvervolt && !regReset;
  a_mask_write_back: assert property (regWrite && regAddr == 8'h0f &&
    !regReset ##1 rdM && !regWrite && !regReset
    |=> regRdata == $past(regWdata, 2)) else $error("mask readback");
  a_reg_reset_mask: assert property (regReset ##1 rdM && !regReset
    && !regWrite |=> regRdata == 8'h00) else $error("mask not cleared");
  a_ov_status_set: assert property (ov [*5] ##0 rdS
    |=> regRdata[7]) else $error("status bit missing");
  a_ov_status_clr: assert property (nov [*5] ##0 rdS
    |=> !regRdata[7]) else $error("status bit stuck");
  a_ov_flag_set: assert property (ov [*6] ##0 rdF
    |=> regRdata[7]) else $error("flag missing");
  a_read_clears_flag: assert property (nov [*5] ##0 rdF ##1
    (nov && !regRead) [*2] ##1 rdF |=> !regRdata[7])
    else $error("flag not cleared");
  a_unmapped_zero: assert property (regRead && regAddr == 8'h20
    |=> regRdata == 8'h00) else $error("unmapped not zero");
  a_rdata_holds: assert property (!regRead && !regReset
    |=> $stable(regRdata)) else $error("read data moved");
  a_irq_reg_reset: assert property (regReset |=> ##1 irq_n)
    else $error("interrupt after register reset");
  c_irq: cover property (!irq_n);
  c_flag: cover property (rdF ##1 regRdata[7]);
  c_rst: cover property (regReset);
endmodule // fai_fault_alarm_regs_monitor
bind fai_fault_alarm_regs fai_fault_alarm_regs_monitor mon (.*);
`default_nettype wire

// File: bench/fai_fault_alarm_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fai_fault_alarm_regs_tb;
  logic       clk, rst_n, regReset, watchdogExpired, regWrite, regRead;
  logic       battOvervolt, battOvercurr, inputOvervolt, inputOvercurr;
  logic [7:0] regAddr, regWdata, alarmEvents, v;
  logic [9:0] battery_thermistor, input_thermistor, dieTemp;
  logic [9:0] battery_temp_fault_level, input_temp_fault_level;
  logic [9:0] die_temp_alarm_level;
  logic [7:0] regRdata;
  logic       irq_n;
  int         bad_count, check_count;
  fai_fault_alarm_regs uut (.*);
  task chk(input string n, input [7:0] s, e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1;
    @(posedge clk);
    regWrite <= 0;
  endtask
  task rd(input [7:0] a);
    regAddr <= a;
    regRead <= 1;
    @(posedge clk);
    regRead <= 0;
    @(posedge clk);
    @(negedge clk) v = regRdata;
    @(posedge clk);
  endtask
  task t_mask;
    wr(8'h0f, 8'ha5);
    rd(8'h0f);
    chk("mask", v, 8'ha5);
    watchdogExpired <= 1;
    @(posedge clk);
    watchdogExpired <= 0;
    rd(8'h0f);
    chk("wdog", v, 8'ha5);
    regReset <= 1;
    @(posedge clk);
    regReset <= 0;
    rd(8'h0f);
    chk("regrst", v, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk("rostat", v, 8'h00);
    rd(8'h20);
    chk("unmapped", v, 8'h00);
    $display("mask done");
  endtask
  task tmp(input [9:0] b, i, d, input [7:0] e);
    battery_thermistor <= b;
    input_thermistor <= i;
    dieTemp <= d;
    repeat (3) @(posedge clk);
    rd(8'h10);
    chk("status", v, e);
  endtask
  task t_temp;
    tmp(10'h032, 10'h1f4, 10'h000, 8'h0c);
    tmp(10'h1f4, 10'h068, 10'h000, 8'h08);
    tmp(10'h1f4, 10'h05a, 10'h000, 8'h0a);
    tmp(10'h1f4, 10'h1f4, 10'h258, 8'h01);
    tmp(10'h1f4, 10'h1f4, 10'h000, 8'h00);
    rd(8'h11);
    chk("tflags", v, 8'h0f);
    battery_temp_fault_level <= 10'h028;
    tmp(10'h032, 10'h1f4, 10'h000, 8'h00);
    $display("temp done");
  endtask
  task t_fault;
    battOvervolt <= 1;
    repeat (6) @(posedge clk);
    rd(8'h10);
    chk("ovstat", v, 8'h80);
    chk("irqon", irq_n, 1'b0);
    rd(8'h11);
    chk("ovflag", v, 8'h80);
    battOvervolt <= 0;
    repeat (6) @(posedge clk);
    rd(8'h11);
    chk("held", v, 8'h80);
    rd(8'h11);
    chk("cleared", v, 8'h00);
    chk("irqoff", irq_n, 1'b1);
    $display("fault done");
  endtask
  task ev;
    alarmEvents <= 8'h04;
    repeat (4) @(posedge clk);
    alarmEvents <= 8'h00;
    repeat (3) @(posedge clk);
  endtask
  task t_alarm;
    wr(8'h0f, 8'h04);
    ev;
    chk("irqmask", irq_n, 1'b1);
    rd(8'h0e);
    wr(8'h0f, 8'h00);
    ev;
    chk("irqopen", irq_n, 1'b0);
    rd(8'h0e);
    chk("alarm", v, 8'h04);
    chk("irqclr", irq_n, 1'b1);
    $display("alarm done");
  endtask
  task t_fmask;
    wr(8'h12, 8'h50);
    rd(8'h12);
    chk("fmask", v, 8'h50);
    battOvercurr <= 1;
    inputOvercurr <= 1;
    repeat (6) @(posedge clk);
    rd(8'h10);
    chk("ocstat", v, 8'h50);
    chk("irqfmask", irq_n, 1'b1);
    battOvercurr <= 0;
    inputOvercurr <= 0;
    inputOvervolt <= 1;
    repeat (6) @(posedge clk);
    chk("irqfopen", irq_n, 1'b0);
    rd(8'h11);
    chk("fflags", v, 8'h70);
    rd(8'h11);
    chk("fsetwin", v, 8'h20);
    inputOvervolt <= 0;
    repeat (6) @(posedge clk);
    regReset <= 1;
    @(posedge clk);
    regReset <= 0;
    rd(8'h12);
    chk("fmrst", v, 8'h00);
    chk("irqrst", irq_n, 1'b1);
    $display("fault mask done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end
  initial
  begin
    {rst_n, regReset, watchdogExpired, regWrite, regRead} = 0;
    {battOvervolt, battOvercurr, inputOvervolt, inputOvercurr} = 0;
    {regAddr, regWdata, alarmEvents, dieTemp} = 0;
    battery_thermistor = 10'h1f4;
    input_thermistor = 10'h1f4;
    battery_temp_fault_level = 10'h064;
    input_temp_fault_level = 10'h064;
    die_temp_alarm_level = 10'h1f4;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_mask;
    t_temp;
    t_fault;
    t_alarm;
    t_fmask;
    give_verdict;
  end
endmodule // fai_fault_alarm_regs_tb
`default_nettype wire
